// ==== hw/uss_fifo.v ====
// synchronous first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module uss_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             aclk,
   input  wire             aresetn,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output reg  [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW:0]      wr_ptr_reg;
   reg [AW:0]      rd_ptr_reg;
   wire            full;
   wire            empty;
   wire            push;
   wire            pop;

   // full and empty from pointer wrap bit
   assign full      = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign empty     = (wr_ptr_reg == rd_ptr_reg);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign push      = in_valid && !full;
   assign pop       = out_ready && !empty;

   // storage write
   always @(posedge aclk) begin
      if (push) begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   // read and write pointers
   always @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_reg <= {(AW+1){1'b0}};
         rd_ptr_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end

   // data output is the head word
   always @* begin
      out_data = mem_reg[rd_ptr_reg[AW-1:0]];
   end
endmodule

// ==== hw/uss_shift_clock.v ====
// serial shift unit clock selection, shift register, counter, clock pin toggle and pin placement
//
// Functional notes
// R01 - with the external clock selected, data out changes through a latch on the edge opposite the sampling edge.
// R02 - with strobe or timer source, the output latch is transparent and data out follows the shift register.
// R03 - source zero: writing one to the soft strobe clocks shift register and counter once; zero clocks neither.
// R04 - source 10 shifts on the rising clock pin edge, 11 on falling; the counter takes both edges or toggle strobes.
// R05 - source 01 clocks shift register and counter from the timer compare match whatever the strobe bit is.
// R06 - with the upper select bit set, the soft strobe bit selects counter clocking instead of strobing.
// R07 - a soft strobe changes the output at once and shifts in the input sampled the cycle before.
// R08 - soft strobe and toggle bits act only on a write of one and always read as zero.
// R09 - writing one to the toggle bit inverts the clock pin output value; it shows only when the pin is an output.
// R10 - external clock with strobe bit set: each toggle write clocks the 4-bit counter directly.
// R11 - pin location register: bits 7 to 1 read zero, bit 0 is read/write and resets to zero.
// R12 - pin location 0 routes in, out and clock to port B bits 0,1,2; 1 routes them to port A bits 4,2,5.
// R13 - wire mode only gates outputs; clocking from the pin and input sampling continue when outputs are off.
// R14 - the 4-bit counter steps by one per selected clock event and wraps from fifteen to zero.
`timescale 1ns/1ps
`include "uss_defines.vh"
module uss_shift_clock (
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite slave
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // timer compare match, same clock domain, one-cycle pulse
   input  wire        timer_match,
   // port pins, port b bits 0..2 and port a bits 2,4,5
   input  wire        pb0_in,
   input  wire        pb2_in,
   input  wire        pa4_in,
   input  wire        pa5_in,
   input  wire        clk_pin_dir_bit,
   input  wire        out_pin_dir_bit,
   output wire        pb1_out,
   output wire        pb1_oe,
   output wire        pb2_out,
   output wire        pb2_oe,
   output wire        pa2_out,
   output wire        pa2_oe,
   output wire        pa5_out,
   output wire        pa5_oe,
   // completed bytes toward the consumer
   output wire [7:0]  rx_data,
   output wire        rx_valid,
   input  wire        rx_ready
);
   // ************************************************************
   // state
   // ************************************************************
   reg  [1:0] clk_src_sel_reg;
   reg        strobe_sel_reg;     // counter select bit when external
   reg  [1:0] wire_mode_sel_reg;
   reg        pin_location_reg;
   reg        clk_pin_val_reg;
   reg  [7:0] shift_reg;
   reg  [7:0] shift_next;
   reg  [3:0] count_reg;
   reg  [3:0] count_next;
   reg        out_latch_reg;
   reg        in_prev_reg;
   reg  [2:0] sin_sync_reg;
   reg  [2:0] sck_sync_reg;
   reg        sck_state_reg;
   reg        sin_state_reg;
   reg        aw_held_reg;
   reg  [3:0] aw_addr_reg;
   reg        w_held_reg;
   reg [31:0] w_data_reg;
   reg        w_strb0_reg;        // lane 0 strobe of the held write
   reg        push_reg;
   reg  [7:0] push_data_reg;
   wire       fifo_ready;
   wire       serial_in_pin;
   wire       shift_clock_pin;
   wire       do_write;
   wire       wr_ctrl;
   wire       strobe_wr;
   wire       toggle_wr;
   wire       sck_rise;
   wire       sck_fall;
   reg        shift_evt;
   reg        count_evt;

   // ************************************************************
   // helpers
   // ************************************************************
   // increment with wrap at fifteen
   function [3:0] inc4;
      input [3:0] v;
      begin
         inc4 = v + 4'h1;
      end
   endfunction

   // ************************************************************
   // pin placement
   // ************************************************************
   // input routing by pin location
   assign serial_in_pin   = pin_location_reg ? pa4_in : pb0_in;   // [R12]
   assign shift_clock_pin = pin_location_reg ? pa5_in : pb2_in;   // [R12]

   // three-stage synchronisers; second and third must agree
   always @(posedge aclk) begin
      if (!aresetn) begin
         sin_sync_reg  <= 3'h0;
         sck_sync_reg  <= 3'h0;
         sin_state_reg <= 1'b0;
         sck_state_reg <= 1'b0;
      end else begin
         sin_sync_reg <= {sin_sync_reg[1:0], serial_in_pin};
         sck_sync_reg <= {sck_sync_reg[1:0], shift_clock_pin};
         if (sin_sync_reg[1] == sin_sync_reg[2]) begin
            sin_state_reg <= sin_sync_reg[2];
         end
         if (sck_sync_reg[1] == sck_sync_reg[2]) begin
            sck_state_reg <= sck_sync_reg[2];
         end
      end
   end

   // clock pin edges, always sampled regardless of wire mode
   assign sck_rise = (sck_sync_reg[1] == sck_sync_reg[2]) && sck_sync_reg[2] && !sck_state_reg;   // [R13]
   assign sck_fall = (sck_sync_reg[1] == sck_sync_reg[2]) && !sck_sync_reg[2] && sck_state_reg;   // [R13]

   // ************************************************************
   // axi4-lite slave
   // ************************************************************
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_ctrl       = do_write && (aw_addr_reg == `USS_OFF_CTRL) && w_strb0_reg;
   assign strobe_wr     = wr_ctrl && w_data_reg[`USS_CTRL_STROBE];   // [R08]
   assign toggle_wr     = wr_ctrl && w_data_reg[`USS_CTRL_TOGGLE];   // [R08]

   // address and data capture in either order, response after both
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         aw_addr_reg  <= 4'h0;
         w_data_reg   <= 32'h0;
         w_strb0_reg  <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[3:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg  <= 1'b1;
            w_data_reg  <= s_axi_wdata;
            w_strb0_reg <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg == `USS_OFF_CTRL || aw_addr_reg == `USS_OFF_PINLOC) ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // register writes for control and pin location
   always @(posedge aclk) begin
      if (!aresetn) begin
         clk_src_sel_reg   <= `USS_CTRL_RST;
         strobe_sel_reg    <= 1'b0;
         wire_mode_sel_reg <= `USS_CTRL_RST;
         pin_location_reg  <= `USS_PINLOC_RST;   // [R11]
      end else if (do_write && w_strb0_reg) begin
         if (aw_addr_reg == `USS_OFF_CTRL) begin
            clk_src_sel_reg   <= w_data_reg[`USS_CTRL_SRC_HI:`USS_CTRL_SRC_LO];
            wire_mode_sel_reg <= w_data_reg[`USS_CTRL_WM_HI:`USS_CTRL_WM_LO];
            strobe_sel_reg    <= w_data_reg[`USS_CTRL_STROBE];   // [R06]
         end
         if (aw_addr_reg == `USS_OFF_PINLOC) begin
            pin_location_reg <= w_data_reg[`USS_PINLOC_POS];   // [R11]
         end
      end
   end

   // reads; strobe and toggle bits read zero, reserved bits zero
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'h0;
         case (s_axi_araddr)   // unaligned offsets fall to the error branch
            `USS_OFF_CTRL:   s_axi_rdata <= {26'h0, wire_mode_sel_reg, clk_src_sel_reg, 2'h0};   // [R08]
            `USS_OFF_DATA:   s_axi_rdata <= {24'h0, shift_reg};
            `USS_OFF_STATUS: s_axi_rdata <= {26'h0, clk_pin_val_reg, strobe_sel_reg, count_reg};
            `USS_OFF_PINLOC: s_axi_rdata <= {31'h0, pin_location_reg};   // [R11]
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ************************************************************
   // clock source selection
   // ************************************************************
   // pick shift and count events per source
   always @* begin
      shift_evt = 1'b0;
      count_evt = 1'b0;
      case (clk_src_sel_reg)
         `USS_SRC_NONE: begin
            shift_evt = strobe_wr;   // [R03]
            count_evt = strobe_wr;   // [R03]
         end
         `USS_SRC_TIMER: begin
            shift_evt = timer_match;   // [R05]
            count_evt = timer_match;   // [R05]
         end
         `USS_SRC_EXT_POS: begin
            shift_evt = sck_rise;   // [R04]
            count_evt = strobe_sel_reg ? toggle_wr : (sck_rise | sck_fall);   // [R04] [R06] [R10]
         end
         `USS_SRC_EXT_NEG: begin
            shift_evt = sck_fall;   // [R04]
            count_evt = strobe_sel_reg ? toggle_wr : (sck_rise | sck_fall);   // [R04] [R06] [R10]
         end
         default: begin
            shift_evt = 1'b0;
            count_evt = 1'b0;
         end
      endcase
   end

   // next values of shift register and counter
   always @* begin
      shift_next = shift_reg;
      count_next = count_reg;
      if (shift_evt) begin
         // strobe shifts in input held from previous cycle
         shift_next = {shift_reg[6:0], clk_src_sel_reg[1] ? sin_state_reg : in_prev_reg};   // [R07]
      end
      if (count_evt) begin
         count_next = inc4(count_reg);   // [R14]
      end
   end

   // ************************************************************
   // shift register, counter, output latch, clock pin value
   // ************************************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         shift_reg       <= 8'h00;
         count_reg       <= 4'h0;
         out_latch_reg   <= 1'b0;
         in_prev_reg     <= 1'b0;
         clk_pin_val_reg <= 1'b0;
         push_reg        <= 1'b0;
         push_data_reg   <= 8'h00;
      end else begin
         shift_reg   <= shift_next;
         count_reg   <= count_next;
         in_prev_reg <= sin_state_reg;
         // latch opens on the edge opposite the sampling edge
         if ((clk_src_sel_reg == `USS_SRC_EXT_POS && sck_fall) ||
             (clk_src_sel_reg == `USS_SRC_EXT_NEG && sck_rise)) begin
            out_latch_reg <= shift_reg[7];   // [R01]
         end
         if (toggle_wr) begin
            clk_pin_val_reg <= !clk_pin_val_reg;   // [R09]
         end
         // completed byte on counter wrap; held until fifo takes it
         if (count_evt && count_reg == 4'hF && !push_reg) begin
            push_reg      <= 1'b1;
            push_data_reg <= shift_next;
         end else if (push_reg && fifo_ready) begin
            push_reg <= 1'b0;
         end
      end
   end

   // ************************************************************
   // pin outputs; wire mode gates only the data out enables, not the clock pin
   // ************************************************************
   wire data_out = clk_src_sel_reg[1] ? out_latch_reg : shift_reg[7];   // [R01] [R02]
   wire out_en   = (wire_mode_sel_reg != 2'h0);                        // [R13]
   assign pb1_out = data_out;
   assign pa2_out = data_out;
   assign pb1_oe  = out_en && out_pin_dir_bit && !pin_location_reg;    // [R12]
   assign pa2_oe  = out_en && out_pin_dir_bit && pin_location_reg;     // [R12]
   assign pb2_out = clk_pin_val_reg;
   assign pa5_out = clk_pin_val_reg;
   assign pb2_oe  = clk_pin_dir_bit && !pin_location_reg;              // [R09] [R12]
   assign pa5_oe  = clk_pin_dir_bit && pin_location_reg;               // [R09] [R12]

   // ************************************************************
   // received byte buffer
   // ************************************************************
   uss_fifo #(
      .WIDTH (`USS_FIFO_WIDTH),
      .DEPTH (`USS_FIFO_DEPTH),
      .AW    (`USS_FIFO_AW)
   ) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_data   (push_data_reg),
      .in_valid  (push_reg),
      .in_ready  (fifo_ready),
      .out_data  (rx_data),
      .out_valid (rx_valid),
      .out_ready (rx_ready)
   );
endmodule

// ==== shared/uss_defines.vh ====
// register map, field positions, reset values and timing for the serial shift clock select block
`ifndef USS_DEFINES_VH
`define USS_DEFINES_VH
// byte offsets on the register bus
`define USS_OFF_CTRL        4'h0
`define USS_OFF_DATA        4'h4
`define USS_OFF_STATUS      4'h8
`define USS_OFF_PINLOC      4'hC
// control register fields
`define USS_CTRL_TOGGLE     0
`define USS_CTRL_STROBE     1
`define USS_CTRL_SRC_LO     2
`define USS_CTRL_SRC_HI     3
`define USS_CTRL_WM_LO      4
`define USS_CTRL_WM_HI      5
// pin location field
`define USS_PINLOC_POS      0
// reset values
`define USS_CTRL_RST        2'h0
`define USS_PINLOC_RST      1'b0
// clock source codes
`define USS_SRC_NONE        2'h0
`define USS_SRC_TIMER       2'h1
`define USS_SRC_EXT_POS     2'h2
`define USS_SRC_EXT_NEG     2'h3
// fifo shape
`define USS_FIFO_WIDTH      8
`define USS_FIFO_DEPTH      16
`define USS_FIFO_AW         4
// timing: system clock period and link clock period in ns
`define USS_CLK_NS          50
`define USS_LINK_NS         400
`define USS_LINK_HALF_CYC   ((`USS_LINK_NS / 2) / `USS_CLK_NS)
`endif

// ==== test/test_uss_shift_clock.sv ====
// self-checking testbench for the serial shift clock select block
`timescale 1ns/1ps
module test_uss_shift_clock;
   logic aclk = 0, aresetn = 0, timer_match = 0, rx_ready = 0;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 0, rv;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   logic clk_pin_dir_bit = 0, out_pin_dir_bit = 1, sin = 0, ext = 0, loc = 0, go = 0, b, s;
   wire pb1_out, pb1_oe, pb2_out, pb2_oe, pa2_out, pa2_oe, pa5_out, pa5_oe, rx_valid, sck, sdi, busy;
   wire [7:0] rx_data, cap;
   logic [7:0] d, a2, q[$];
   logic [1:0] rr;
   int n_fail = 0, comparisons = 0, i, k, j, c;
   // pin routing: the unselected location sees an idle clock and inverted data
   wire din = ext ? sdi : sin;
   wire pb0_in = loc ? ~din : din;
   wire pa4_in = loc ? din : ~din;
   wire pb2_in = loc ? 1'b0 : sck;
   wire pa5_in = loc ? sck : 1'b0;
   wire dout = loc ? (pa2_oe ? pa2_out : 1'b1) : (pb1_oe ? pb1_out : 1'b1);
   uss_shift_clock dut (.*);
   uss_link_master peer (.go(go), .tx_byte(d), .dout(dout), .sck(sck), .sdi(sdi), .cap(cap), .busy(busy));
   initial begin
      forever #25 aclk = ~aclk;
   end
   task finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task tmo;
      n_fail++;
      $display("mismatch at %0t: wait ran out", $time);
      finish_test;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // one register access; handshakes seen settled before the edge that takes them
   task axi(input logic wr, input logic [3:0] a, input logic [31:0] dat);
      logic ta, tw, tr, done;
      done = 0;
      if (wr) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= dat;
         s_axi_awvalid <= 1;
         s_axi_wvalid <= 1;
         s_axi_bready <= 1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1;
         s_axi_rready <= 1;
      end
      for (int n = 0; n < 50 && !done; n++) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tr = s_axi_arvalid && s_axi_arready;
         done = wr ? s_axi_bvalid : s_axi_rvalid;
         rr = wr ? s_axi_bresp : s_axi_rresp;
         rv = s_axi_rdata;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
         if (tr) s_axi_arvalid <= 0;
         if (done) begin
            s_axi_bready <= 0;
            s_axi_rready <= 0;
         end
      end
      @(posedge aclk);   // let an edge pass before the next request
      if (!done) tmo;
   endtask
   task pulse(input int n);
      repeat (n) begin
         timer_match <= 1;
         @(posedge aclk);
         timer_match <= 0;
         cyc(5);
      end
   endtask
   task frame;
      go <= 1;
      @(posedge aclk);
      go <= 0;
      for (i = 0; busy && i < 200; i++) @(posedge aclk);
      if (busy) tmo;
      cyc(10);
   endtask
   task pop;
      i = 0;
      do begin
         @(negedge aclk);
         i++;
      end while (!rx_valid && i < 40);
      if (!rx_valid) tmo;
      @(posedge aclk) rx_ready <= 1;
      @(posedge aclk) rx_ready <= 0;
   endtask
   // ********************
   // main sequence
   // ********************
   initial begin
      void'($urandom(48));
      cyc(8);
      aresetn <= 1;
      @(posedge aclk);
      axi(0, 4'h8, 0); chk(rv, 0);
      axi(0, 4'hC, 0); chk(rv, 0);
      axi(1, 4'hC, 32'hFF); axi(0, 4'hC, 0); chk(rv, 1);
      axi(1, 4'hC, 0);
      axi(0, 4'h2, 0); chk(rr, 2'h2);
      $display("registers done");
      // soft strobe with random input bits and random strobe bits
      axi(0, 4'h4, 0); d = rv[7:0]; axi(0, 4'h8, 0); c = rv[3:0];
      for (k = 0; k < 20; k++) begin
         b = $urandom % 2;
         s = (k < 2) ? k : $urandom % 2;
         sin <= b;
         cyc(6);
         axi(1, 4'h0, s ? 32'h12 : 32'h10);
         if (s) begin
            d = {d[6:0], b};
            c = (c + 1) % 16;
         end
         axi(0, 4'h4, 0); chk(rv, d);
         axi(0, 4'h8, 0); chk(rv[3:0], c);
         chk(pb1_out, d[7]);
         axi(0, 4'h0, 0); chk(rv[1:0], 0);
      end
      $display("strobe done");
      clk_pin_dir_bit <= 1; axi(0, 4'h8, 0); b = rv[5];
      axi(1, 4'h0, 32'h11); axi(0, 4'h8, 0); chk(rv[5], !b);
      chk(pb2_out, !b); chk(pb2_oe, 1);
      clk_pin_dir_bit <= 0; axi(1, 4'h0, 32'h11); chk(pb2_out, b); chk(pb2_oe, 0);
      axi(0, 4'h8, 0); c = rv[3:0]; axi(1, 4'h0, 32'h14);
      axi(1, 4'h0, 32'h16); pulse(5); axi(0, 4'h8, 0); chk(rv[3:0], (c + 5) % 16);
      axi(1, 4'h0, 32'h1E); axi(0, 4'h8, 0); c = rv[3:0];
      repeat (3) axi(1, 4'h0, 32'h1F);
      axi(0, 4'h8, 0); chk(rv[3:0], (c + 3) % 16);
      $display("toggle and timer done");
      // align counter to zero, then empty the buffer
      c = rv[3:0]; axi(1, 4'h0, 32'h14); pulse((16 - c) % 16);
      rx_ready <= 1; cyc(40); rx_ready <= 0; @(posedge aclk);
      ext <= 1; axi(1, 4'h0, 32'h18); d = $urandom; frame;
      axi(0, 4'h4, 0); chk(rv, d);
      axi(0, 4'h8, 0); chk(rv[3:0], 0);
      chk(rx_data, d); pop;
      axi(1, 4'hC, 1); loc <= 1; a2 = d; d = $urandom; frame;
      chk(cap, a2);
      chk(pa2_oe, 1); chk(pb1_oe, 0);
      axi(0, 4'h4, 0); chk(rv, d); pop;
      loc <= 0; ext <= 0; axi(1, 4'hC, 0);
      $display("frames done");
      // fill the buffer past its depth while stalled, then drain in order
      axi(1, 4'h0, 32'h14);
      for (k = 0; k < 17; k++) begin
         d = $urandom;
         q.push_back(d);
         for (j = 0; j < 16; j++) begin
            sin <= d[7 - j % 8];
            cyc(5);
            pulse(1);
         end
      end
      for (k = 0; k < 17; k++) begin
         i = 0;
         do begin
            @(negedge aclk);
            i++;
         end while (!rx_valid && i < 40);
         chk(rx_data, q.pop_front());
         @(posedge aclk) rx_ready <= 1;
         @(posedge aclk) rx_ready <= 0;
      end
      cyc(5); chk(rx_valid, 0);
      $display("buffer done");
      finish_test;
   end
endmodule

// ==== test/uss_link_master.sv ====
// external serial master: clocks one byte per start, captures the data out line
`timescale 1ns/1ps
module uss_link_master (
   input wire logic       go,
   input wire logic [7:0] tx_byte,
   input wire logic       dout,
   output logic           sck,
   output logic           sdi,
   output logic [7:0]     cap,
   output logic           busy
);
   // clock idles low between frames, data shows inverse of last bit when idle
   initial begin
      sck = 0;
      sdi = 0;
      cap = 0;
      busy = 0;
      forever begin
         @(posedge go);
         busy = 1;
         #37;
         for (int i = 7; i >= 0; i--) begin
            sdi = tx_byte[i];
            #200 sck = 1;
            #199 cap = {cap[6:0], dout};
            #1 sck = 0;
         end
         #200 sdi = ~sdi;
         busy = 0;
      end
   end
endmodule

// ==== test/uss_shift_clock_sva.sv ====
// checker for the serial shift clock select block ports
`timescale 1ns/1ps
module uss_shift_clock_sva (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [3:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        clk_pin_dir_bit,
   input wire logic        out_pin_dir_bit,
   input wire logic        pb1_oe,
   input wire logic        pb2_oe,
   input wire logic        pa2_oe,
   input wire logic        pa5_oe,
   input wire logic [7:0]  rx_data,
   input wire logic        rx_valid,
   input wire logic        rx_ready
);
   // one clock domain, synchronous low reset
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response changed early");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answering");
   a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   a_ctrl_strobes_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0
      |=> s_axi_rdata[1:0] == 2'h0) else $error("strobe bits read nonzero");
   a_pinloc_reserved: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hC
      |=> s_axi_rdata[31:1] == 31'h0) else $error("reserved location bits nonzero");
   a_clk_pin_dir: assert property (!clk_pin_dir_bit |-> !pb2_oe && !pa5_oe)
      else $error("clock pin driven as input");
   a_one_location: assert property (!(pb2_oe && pa5_oe) && !(pb1_oe && pa2_oe))
      else $error("both pin locations driven");
   a_out_dir_gate: assert property (!out_pin_dir_bit |-> !pb1_oe && !pa2_oe)
      else $error("data out driven as input");
   a_rx_holds: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("buffer head changed while stalled");
   cover property (rx_valid && !rx_ready);
   cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   cover property (pa2_oe && !pb1_oe);
endmodule
bind uss_shift_clock uss_shift_clock_sva chk (.*);
